// ### src/i2c_slave_with_timeout.sv
// two-wire slave with bus time-out, wishbone register slave
//
// Summary of operation
// - timeout_enable bit gates time-out function
// - timeout_flag set by hardware, cleared by software
// - time-out tick is sub clock over 32
// - all bytes pass through bus_data register; the address byte is not stored there
// - own address upper seven bits, bit0 zero
// - first seven bits compared, match sets flag
// - eighth bit stored as master read request
// - address match drives ninth-bit acknowledge low
// - start condition detected sets bus busy
// - data bytes eight bits, msb first
// - receiver drives ack_to_send on ninth clock
// - master nack: release data, await stop
// - one interrupt from match, time-out, byte
// - counter starts on match, cleared by scl fall
// - stop condition halts time-out function
// - overflow: halt, disable, set flag, interrupt
// - time-out resets logic and flag register
// - stop condition clears bus busy
// - byte complete flag set after each byte; the address byte does not set it
// - master ninth-clock ack stored in ack_received_flag
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_with_timeout
  import i2c_slave_pkg::*;
(
  input  wire logic        clk_i,      // system clock 100 MHz
  input  wire logic        rst_i,      // sync reset, active high
  input  wire logic        wb_cyc_i,   // wishbone cycle
  input  wire logic        wb_stb_i,   // wishbone strobe
  input  wire logic        wb_we_i,    // wishbone write
  input  wire logic [7:0]  wb_adr_i,   // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,   // wishbone byte select
  input  wire logic [31:0] wb_dat_i,   // wishbone write data
  output logic      [31:0] wb_dat_o,   // wishbone read data
  output logic             wb_ack_o,   // wishbone acknowledge
  input  wire logic        scl_i,      // serial clock pin level
  output logic             scl_o,      // serial clock drive value
  output logic             scl_oe_o,   // serial clock pull low
  input  wire logic        sda_i,      // serial data pin level
  output logic             sda_o,      // serial data drive value
  output logic             sda_oe_o,   // serial data pull low
  input  wire logic        sub_clk_i,  // low-speed sub clock
  output logic             irq_o       // interface interrupt pulse
);

  ////////////////////////////////////////////////////////////////////////////
  state_t      st_q;
  logic [2:0]  cnt_q;
  logic [7:0]  sh_q;
  logic        ack_on_q;
  logic        sda_oe_q;
  logic        scl_oe_q;
  logic [7:0]  data_q;
  logic [6:0]  own_q;
  logic        en_q;
  logic        ie_q;
  logic        to_en_q;
  logic        to_flag_q;
  logic [5:0]  to_sel_q;
  logic [6:0]  to_cnt_q;
  logic        run_q;
  logic [4:0]  div_q;
  logic        hcf_q;
  logic        haas_q;
  logic        busy_q;
  logic        tx_q;
  logic        txak_q;
  logic        srw_q;
  logic        rxak_q;
  logic        irq_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        scl_m_q;
  logic        scl_s_q;
  logic        scl_p_q;
  logic        sda_m_q;
  logic        sda_s_q;
  logic        sda_p_q;
  logic        sub_m_q;
  logic        sub_s_q;
  logic        sub_p_q;
  logic [7:0]  rdata;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  logic [7:0] adr;
  logic       req;
  logic       wr;
  logic       data_acc;
  assign adr      = {wb_adr_i[7:2], 2'b00};
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign data_acc = req & (adr == ADR_DATA) & (~wb_we_i | wb_sel_i[0]);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; edges compare the second and third stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {sub_m_q, sub_s_q, sub_p_q} <= 3'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      {sub_m_q, sub_s_q, sub_p_q} <= {sub_clk_i, sub_m_q, sub_s_q};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = en_q & scl_s_q & ~scl_p_q;
  assign scl_fall  = en_q & ~scl_s_q & scl_p_q;
  assign start_det = en_q & scl_s_q & scl_p_q & ~sda_s_q & sda_p_q;
  assign stop_det  = en_q & scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus events
  logic addr_done;
  logic match_ev;
  logic byte_done;
  logic ack_rise;
  logic to_fire;
  logic bus_rst;
  logic sub_rise;
  logic tick;
  assign addr_done = (st_q == ST_ADDR) & scl_rise & (cnt_q == LAST_BIT);
  assign match_ev  = addr_done & (sh_q[6:0] == own_q);
  assign byte_done = (st_q == ST_DATA) & scl_rise & (cnt_q == LAST_BIT);
  assign ack_rise  = (st_q == ST_DACK) & tx_q & ack_on_q & scl_rise;
  assign to_fire   = run_q & to_en_q & tick & (to_cnt_q == {1'b0, to_sel_q});
  // a time-out clears the serial engine like a disable does
  assign bus_rst   = rst_i | to_fire | ~en_q;

  ////////////////////////////////////////////////////////////////////////////
  // sub clock divider: one tick per 32 sub clock periods
  assign sub_rise = sub_s_q & ~sub_p_q;
  assign tick     = sub_rise & (div_q == SUB_DIV_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 5'h00;
    end else if (sub_rise) begin
      div_q <= div_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time-out counter
  always_ff @(posedge clk_i) begin
    if (rst_i || match_ev || scl_fall) begin
      to_cnt_q <= 7'h00;
    end else if (run_q && to_en_q && tick && !to_fire) begin
      to_cnt_q <= to_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || to_fire || stop_det || !en_q) begin
      run_q <= 1'b0;
    end else if (match_ev) begin
      run_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_en_q   <= TOC_RST[T_EN];
      to_flag_q <= TOC_RST[T_FLAG];
      to_sel_q  <= TOC_RST[T_SEL:0];
    end else begin
      if (wr && adr == ADR_TOC) begin
        to_en_q   <= wb_dat_i[T_EN];
        to_flag_q <= wb_dat_i[T_FLAG];
        to_sel_q  <= wb_dat_i[T_SEL:0];
      end
      // set after the write so an overflow is never lost
      if (to_fire) begin
        to_en_q   <= 1'b0;
        to_flag_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable and address registers, untouched by a time-out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q  <= ENABLE_RST[EN_EN_BIT];
      ie_q  <= ENABLE_RST[EN_IE_BIT];
      own_q <= OWN_RST[7:1];
    end else if (wr) begin
      if (adr == ADR_ENABLE) begin
        en_q <= wb_dat_i[EN_EN_BIT];
        ie_q <= wb_dat_i[EN_IE_BIT];
      end
      if (adr == ADR_OWN) begin
        own_q <= wb_dat_i[7:1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= DATA_RST;
    end else if (wr && adr == ADR_DATA) begin
      data_q <= wb_dat_i[7:0];
    end else if (byte_done && !tx_q) begin
      data_q <= {sh_q[6:0], sda_s_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge clk_i) begin
    if (bus_rst) begin
      hcf_q  <= FLAGS_RST[F_HCF];
      haas_q <= FLAGS_RST[F_HAAS];
      busy_q <= FLAGS_RST[F_HBB];
      tx_q   <= FLAGS_RST[F_HTX];
      txak_q <= FLAGS_RST[F_TXAK];
      srw_q  <= FLAGS_RST[F_SRW];
      rxak_q <= FLAGS_RST[F_RXAK];
    end else begin
      if (wr && adr == ADR_FLAGS) begin
        tx_q   <= wb_dat_i[F_HTX];
        txak_q <= wb_dat_i[F_TXAK];
      end
      if (data_acc) begin
        hcf_q <= 1'b0;
      end
      if (start_det) begin
        busy_q <= 1'b1;
        hcf_q  <= 1'b0;
        haas_q <= 1'b0;
      end
      if (stop_det) begin
        busy_q <= 1'b0;
        hcf_q  <= 1'b1;
      end
      if (match_ev) begin
        haas_q <= 1'b1;
        srw_q  <= sda_s_q;
      end
      if (byte_done) begin
        hcf_q <= 1'b1;
      end
      if (ack_rise) begin
        rxak_q <= sda_s_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial engine: sample on scl rise, change sda on scl fall or, for the first transmit bit, on the data write
  always_ff @(posedge clk_i) begin
    if (bus_rst) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 3'h0;
      sh_q     <= 8'h00;
      ack_on_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (start_det) begin
      st_q     <= ST_ADDR;
      cnt_q    <= 3'h0;
      ack_on_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (stop_det) begin
      st_q     <= ST_IDLE;
      ack_on_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      if (data_acc && scl_oe_q) begin
        scl_oe_q <= 1'b0;
      end
      // first bit goes out in the same cycle that scl is let go
      if (wr && adr == ADR_DATA && tx_q && scl_oe_q && st_q == ST_DATA) begin
        sh_q     <= wb_dat_i[7:0];
        sda_oe_q <= ~wb_dat_i[7];
      end
      unique case (st_q)
        ST_IDLE, ST_WAIT: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == LAST_BIT) begin
              st_q <= match_ev ? ST_ACK : ST_WAIT;
            end
          end
        end
        ST_ACK, ST_DACK: begin
          if (scl_fall && !ack_on_q) begin
            ack_on_q <= 1'b1;
            // address ack is always low; data ack follows ack_to_send
            sda_oe_q <= (st_q == ST_ACK) | (~tx_q & ~txak_q);
          end else if (scl_fall) begin
            ack_on_q <= 1'b0;
            sda_oe_q <= 1'b0;
            cnt_q    <= 3'h0;
            if (st_q == ST_DACK && tx_q && rxak_q) begin
              st_q <= ST_WAIT;
            end else begin
              st_q     <= ST_DATA;
              scl_oe_q <= 1'b1;
            end
          end
        end
        ST_DATA: begin
          if (scl_rise) begin
            if (!tx_q) begin
              sh_q <= {sh_q[6:0], sda_s_q};
            end
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == LAST_BIT) begin
              st_q <= ST_DACK;
            end
          end else if (scl_fall && tx_q) begin
            sh_q     <= {sh_q[6:0], 1'b0};
            sda_oe_q <= ~sh_q[6];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and register bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ie_q & (match_ev | to_fire | byte_done);
    end
  end

  always_comb begin
    unique case (adr)
      ADR_ENABLE: rdata = {6'h00, en_q, ie_q};
      ADR_FLAGS:  rdata = {hcf_q, haas_q, busy_q, tx_q, txak_q, srw_q, 1'b0, rxak_q};
      ADR_DATA:   rdata = data_q;
      ADR_OWN:    rdata = {own_q, 1'b0};
      ADR_TOC:    rdata = {to_en_q, to_flag_q, to_sel_q};
      default:    rdata = 8'h00;
    endcase
  end

  // one wait state; unmapped addresses answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= (req && !wb_we_i) ? {24'h000000, rdata} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign scl_oe_o = scl_oe_q;
  assign sda_oe_o = sda_oe_q;
  assign irq_o    = irq_q;
  // open-drain: only ever pulls low
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a disabled time-out must leave the counter idle
  property p_to_off;
    !to_en_q |=> $stable(to_cnt_q) || to_cnt_q == 7'h00;
  endproperty
  a_to_off: assert property (p_to_off) else $error("time-out while disabled");

  property p_to_flag;
    to_fire |=> to_flag_q && !to_en_q && !run_q && irq_o == $past(ie_q);
  endproperty
  a_to_flag: assert property (p_to_flag) else $error("time-out effects missing");

  property p_flag_hold;
    to_flag_q && !(wr && adr == ADR_TOC) |=> to_flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("time-out flag lost");

  property p_to_reset;
    to_fire |=> st_q == ST_IDLE && hcf_q && rxak_q && !busy_q && !haas_q && !scl_oe_q;
  endproperty
  a_to_reset: assert property (p_to_reset) else $error("no reset on time-out");

  property p_period;
    run_q && to_en_q && tick && to_cnt_q > {1'b0, to_sel_q} |-> 1'b0;
  endproperty
  a_period: assert property (p_period) else $error("count past setting");

  property p_busy;
    start_det |=> busy_q ##0 (!stop_det [*1]);
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set");

  property p_free;
    stop_det |=> !busy_q && !run_q;
  endproperty
  a_free: assert property (p_free) else $error("stop not seen");

  property p_match;
    match_ev |=> haas_q && srw_q == $past(sda_s_q) && st_q == ST_ACK;
  endproperty
  a_match: assert property (p_match) else $error("match not recorded");

  property p_addr_ack;
    st_q == ST_ACK && scl_fall && !ack_on_q && !stop_det |=> sda_oe_q;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

  property p_rx_ack;
    st_q == ST_DACK && !tx_q && scl_fall && !ack_on_q && !stop_det |=> sda_oe_q == !$past(txak_q);
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("wrong data ack");

  property p_nack;
    st_q == ST_DACK && tx_q && rxak_q && scl_fall && ack_on_q && !stop_det
      |=> st_q == ST_WAIT && !sda_oe_q && !scl_oe_q;
  endproperty
  a_nack: assert property (p_nack) else $error("nack not released");

  property p_stretch;
    data_acc && scl_oe_q && !bus_rst && !start_det |=> !scl_oe_q;
  endproperty
  a_stretch: assert property (p_stretch) else $error("scl not released");

  property p_lsb;
    wb_ack_o && $past(adr) == ADR_OWN |-> wb_dat_o[0] == 1'b0;
  endproperty
  a_lsb: assert property (p_lsb) else $error("address bit0 not zero");

  c_match:   cover property (match_ev ##1 st_q == ST_ACK);
  c_timeout: cover property (to_fire);
  c_rx_byte: cover property (byte_done && !tx_q);
  c_tx_nack: cover property (st_q == ST_DACK && tx_q ##1 st_q == ST_WAIT);

endmodule : i2c_slave_with_timeout
`default_nettype wire

// ### src/i2c_slave_pkg.sv
// constants, register map and states of the two-wire slave
package i2c_slave_pkg;
  // register byte addresses
  localparam logic [7:0] ADR_ENABLE = 8'h00;
  localparam logic [7:0] ADR_FLAGS  = 8'h04;
  localparam logic [7:0] ADR_DATA   = 8'h08;
  localparam logic [7:0] ADR_OWN    = 8'h0C;
  localparam logic [7:0] ADR_TOC    = 8'h10;
  // enable_control_register fields
  localparam int unsigned EN_IE_BIT = 0;
  localparam int unsigned EN_EN_BIT = 1;
  // flag_control_register fields
  localparam int unsigned F_HCF  = 7;
  localparam int unsigned F_HAAS = 6;
  localparam int unsigned F_HBB  = 5;
  localparam int unsigned F_HTX  = 4;
  localparam int unsigned F_TXAK = 3;
  localparam int unsigned F_SRW  = 2;
  localparam int unsigned F_RXAK = 0;
  // timeout_control fields
  localparam int unsigned T_EN   = 7;
  localparam int unsigned T_FLAG = 6;
  localparam int unsigned T_SEL  = 5;
  // reset values
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST  = 8'h81;
  localparam logic [7:0] OWN_RST    = 8'h00;
  localparam logic [7:0] TOC_RST    = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;
  // time-out clock is the sub clock divided by this
  localparam int unsigned SUB_DIV      = 32;
  localparam logic [4:0]  SUB_DIV_LAST = 5'(SUB_DIV - 1);
  localparam logic [2:0]  LAST_BIT     = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_DATA,
    ST_DACK,
    ST_WAIT
  } state_t;
endpackage : i2c_slave_pkg

// ### sim/i2c_master_model.sv
// behavioural two-wire bus master on open-drain lines
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model #(
  parameter int HALF = 20  // system clocks per hold; one bit spans three holds
) (
  input  wire logic clk_i,     // system clock
  input  wire logic scl_i,     // resolved clock line
  input  wire logic sda_i,     // resolved data line
  output var  logic scl_oe_o,  // pull clock line low
  output var  logic sda_oe_o   // pull data line low
);
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end

  task automatic hold();
    repeat (HALF) @(posedge clk_i);
  endtask : hold

  // release clock, then wait out a stretch by the slave of up to 4000 clocks
  task automatic rise();
    int n;
    n = 0;
    scl_oe_o <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (scl_i !== 1'b1 && n < 4000);
    hold();
  endtask : rise

  task automatic start();
    sda_oe_o <= 1'b0;
    hold();
    rise();
    sda_oe_o <= 1'b1;
    hold();
    scl_oe_o <= 1'b1;
    hold();
  endtask : start

  task automatic stop();
    sda_oe_o <= 1'b1;
    hold();
    rise();
    sda_oe_o <= 1'b0;
    hold();
  endtask : stop

  // data changes only while clock is low; sampled at clock high
  task automatic bit_io(input logic b, output logic q);
    sda_oe_o <= !b;
    hold();
    rise();
    q = sda_i;
    scl_oe_o <= 1'b1;
    hold();
  endtask : bit_io

  // d=FF lets the slave drive; ack_in is our ninth bit
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// ### sim/i2c_slave_with_timeout_test.sv
// self-checking bench for the two-wire slave with bus time-out
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_with_timeout_test;
  import i2c_slave_pkg::*;
  localparam int SUBP = 8;  // system clocks per sub clock period
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        sub_clk = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack, scl_oe, sda_oe, m_scl_oe, m_sda_oe, irq, scl_dv, sda_dv;
  wire         scl = !(scl_oe | m_scl_oe);  // pull-up unless pulled low
  wire         sda = !(sda_oe | m_sda_oe);
  int          failures = 0, checked = 0, cycles = 0, irqs = 0, i;
  logic [7:0]  q, own, d;
  logic        a;

  i2c_slave_with_timeout dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_dv),
    .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_dv), .sda_oe_o(sda_oe),
    .sub_clk_i(sub_clk), .irq_o(irq));
  i2c_master_model m (.clk_i(clk_i), .scl_i(scl), .sda_i(sda),
    .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));

  always #5 clk_i = ~clk_i;
  always #40 sub_clk = ~sub_clk;
  always @(posedge clk_i) begin
    cycles++;
    if (irq === 1'b1) irqs++;
    if (cycles > 40000) begin
      failures++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////
  function automatic int tick_clks(int n);
    return n * SUB_DIV * SUBP;
  endfunction : tick_clks

  function automatic logic [7:0] abyte(logic [7:0] o, logic rw);
    return {o[7:1], rw};
  endfunction : abyte

  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h want %h", $time, s, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] v,
                    output logic [7:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= {24'h000000, v};
    // only the bench timeout ends this wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    logic [7:0] r;
    wb(1'b1, ad, v, r);
  endtask : wr

  task automatic rdc(input logic [7:0] ad, input logic [7:0] mk, input logic [7:0] e,
                     input string s);
    logic [7:0] r;
    wb(1'b0, ad, 8'h00, r);
    chk(r & mk, e, s);
  endtask : rdc

  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h58100d69));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(ADR_ENABLE, 8'hFF, ENABLE_RST, "enable rst");
    rdc(ADR_FLAGS, 8'hFF, 8'h81, "flags rst");
    rdc(ADR_OWN, 8'hFF, 8'h00, "own rst");
    rdc(ADR_TOC, 8'hFF, 8'h00, "toc rst");
    rdc(8'h14, 8'hFF, 8'h00, "unmapped");
    own = 8'($urandom_range(2, 253)) | 8'h01;
    wr(ADR_ENABLE, 8'h02);
    wr(ADR_OWN, own);
    wr(ADR_ENABLE, 8'h03);
    rdc(ADR_OWN, 8'hFF, own & 8'hFE, "own bit0");
    // foreign address is ignored
    i = irqs;
    m.start();
    m.xfer(abyte(own ^ 8'h02, 1'b0), 1'b1, q, a);
    chk({7'h0, a}, 8'h01, "no-match ack");
    chk(8'(irqs - i), 8'h00, "no-match irq");
    m.stop();
    // master writes two bytes, second refused via ack_to_send
    m.start();
    rdc(ADR_FLAGS, 8'hA0, 8'h20, "busy after start");
    i = irqs;
    m.xfer(abyte(own, 1'b0), 1'b1, q, a);
    chk({7'h0, a}, 8'h00, "addr ack");
    chk(8'(irqs - i), 8'h01, "match irq");
    rdc(ADR_FLAGS, 8'h44, 8'h40, "match, write");
    chk({7'h0, scl_oe}, 8'h01, "stretch");
    wr(ADR_FLAGS, 8'h00);
    rdc(ADR_DATA, 8'hFF, DATA_RST, "dummy read");
    chk({7'h0, scl_oe}, 8'h00, "released");
    d = 8'($urandom());
    m.xfer(d, 1'b1, q, a);
    chk({7'h0, a}, 8'h00, "data ack");
    rdc(ADR_FLAGS, 8'h80, 8'h80, "byte done");
    wr(ADR_FLAGS, 8'h08);
    rdc(ADR_DATA, 8'hFF, d, "rx byte");
    d = 8'h01;
    m.xfer(d, 1'b1, q, a);
    chk({7'h0, a}, 8'h01, "data nack");
    rdc(ADR_DATA, 8'hFF, d, "rx byte2");
    m.stop();
    rdc(ADR_FLAGS, 8'hA0, 8'h80, "stop");
    // master reads two bytes, refuses the second
    wr(ADR_FLAGS, 8'h00);
    m.start();
    m.xfer(abyte(own, 1'b1), 1'b1, q, a);
    chk({7'h0, a}, 8'h00, "read addr ack");
    rdc(ADR_FLAGS, 8'h44, 8'h44, "match, read");
    wr(ADR_FLAGS, 8'h10);
    d = 8'h80;
    wr(ADR_DATA, d);
    m.xfer(8'hFF, 1'b0, q, a);
    chk(q, d, "tx byte");
    rdc(ADR_FLAGS, 8'h01, 8'h00, "master ack");
    d = 8'($urandom());
    wr(ADR_DATA, d);
    m.xfer(8'hFF, 1'b1, q, a);
    chk(q, d, "tx byte2");
    rdc(ADR_FLAGS, 8'h01, 8'h01, "master nack");
    chk({7'h0, sda_oe}, 8'h00, "sda freed");
    chk({6'h00, scl_dv, sda_dv}, 8'h00, "drive level");
    m.stop();
    // time-out disabled: stretch persists
    wr(ADR_FLAGS, 8'h00);
    wr(ADR_TOC, 8'h03);
    m.start();
    m.xfer(abyte(own, 1'b0), 1'b1, q, a);
    repeat (tick_clks(5)) @(posedge clk_i);
    rdc(ADR_TOC, 8'hFF, 8'h03, "toc off");
    chk({7'h0, scl_oe}, 8'h01, "still held");
    rdc(ADR_DATA, 8'hFF, d, "dummy");
    m.stop();
    // time-out enabled with a held clock line
    wr(ADR_TOC, 8'h83);
    m.start();
    i = irqs;
    m.xfer(abyte(own, 1'b0), 1'b1, q, a);
    repeat (tick_clks(3) - 100) @(posedge clk_i);
    rdc(ADR_TOC, 8'h40, 8'h00, "not yet");
    repeat (tick_clks(1) + 200) @(posedge clk_i);
    rdc(ADR_TOC, 8'hFF, 8'h43, "timed out");
    chk(8'(irqs - i), 8'h02, "timeout irq");
    rdc(ADR_FLAGS, 8'hFF, FLAGS_RST, "flags reset");
    chk({7'h0, scl_oe}, 8'h00, "lines free");
    rdc(ADR_OWN, 8'hFF, own & 8'hFE, "own kept");
    rdc(ADR_ENABLE, 8'hFF, 8'h03, "enable kept");
    rdc(ADR_TOC, 8'h40, 8'h40, "flag sticks");
    wr(ADR_TOC, 8'h03);
    rdc(ADR_TOC, 8'hFF, 8'h03, "flag cleared");
    m.stop();
    close_out();
  end
endmodule : i2c_slave_with_timeout_test
`default_nettype wire
